// ==== inc/ps_bank_pkg.sv ====
package ps_bank_pkg;

  // ----------------------------------------
  // status numbers
  // ----------------------------------------
  localparam logic [7:0] NUM_RAM_BASE    = 8'h00;
  localparam logic [7:0] NUM_VEC_BASE    = 8'h01;
  localparam logic [7:0] NUM_TILE_CTL    = 8'h02;
  localparam logic [7:0] NUM_BOOT_STAT   = 8'h03;
  localparam logic [7:0] NUM_SEC_COPY    = 8'h05;
  localparam logic [7:0] NUM_OSC_CTL     = 8'h06;
  localparam logic [7:0] NUM_CNT_T_CELL  = 8'h07;
  localparam logic [7:0] NUM_CNT_T_WIRE  = 8'h08;
  localparam logic [7:0] NUM_CNT_P_CELL  = 8'h09;
  localparam logic [7:0] NUM_CNT_P_WIRE  = 8'h0a;
  localparam logic [7:0] NUM_DBG_STATUS  = 8'h10;
  localparam logic [7:0] NUM_DBG_PC      = 8'h11;
  localparam logic [7:0] NUM_DBG_SP      = 8'h12;
  localparam logic [7:0] NUM_DGR_CORE    = 8'h13;
  localparam logic [7:0] NUM_DGR_REG     = 8'h14;
  localparam logic [7:0] NUM_DBG_CAUSE   = 8'h15;
  localparam logic [7:0] NUM_DBG_DATA    = 8'h16;
  localparam logic [7:0] NUM_CORE_STOP   = 8'h18;
  localparam logic [7:0] NUM_SCRATCH     = 8'h20;
  localparam logic [7:0] NUM_IBP_ADDR    = 8'h30;
  localparam logic [7:0] NUM_IBP_CTL     = 8'h40;
  localparam logic [7:0] NUM_DWP_LO      = 8'h50;
  localparam logic [7:0] NUM_DWP_HI      = 8'h60;
  localparam logic [7:0] NUM_DWP_CTL     = 8'h70;
  localparam logic [7:0] NUM_RWP_MASK    = 8'h80;
  localparam logic [7:0] NUM_RWP_VAL     = 8'h90;
  localparam logic [7:0] NUM_RWP_CTL     = 8'h9c;
  localparam int         SCRATCH_CNT     = 8;
  localparam int         UNIT_CNT        = 4;

  // ----------------------------------------
  // write masks and reset values
  // ----------------------------------------
  localparam logic [31:0] RAM_BASE_RST   = 32'h0001_0000;
  localparam logic [31:0] RAM_BASE_MASK  = 32'hffff_fffc;
  localparam logic [31:0] VEC_BASE_MASK  = 32'hffff_0000;
  localparam logic [31:0] DGR_CORE_MASK  = 32'h0000_00ff;
  localparam logic [31:0] DGR_REG_MASK   = 32'h0000_001f;
  localparam logic [31:0] CAUSE_MASK     = 32'h0003_ff07;
  localparam logic [31:0] CORE_STOP_MASK = 32'h0000_00ff;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TILE_DIV_EN_BIT  = 4;
  localparam int TILE_DIV_DYN_BIT = 5;
  localparam int OSC_PERIPH_BIT   = 0;
  localparam int OSC_TILE_BIT     = 1;
  localparam int BOOT_OTP_BIT     = 8;
  localparam int BOOT_TILE_LSB    = 16;
  localparam int CAUSE_CORE_LSB   = 8;
  localparam int CAUSE_UNIT_LSB   = 16;

  // ----------------------------------------
  // debug causes
  // ----------------------------------------
  localparam logic [2:0] CAUSE_NONE      = 3'h0;
  localparam logic [2:0] CAUSE_HOST      = 3'h1;
  localparam logic [2:0] CAUSE_CALL      = 3'h2;
  localparam logic [2:0] CAUSE_INSTR_BP  = 3'h3;
  localparam logic [2:0] CAUSE_DATA_WP   = 3'h4;
  localparam logic [2:0] CAUSE_RES_WP    = 3'h5;

endpackage

// ==== rtl/processor_status_register_bank.sv ====
`timescale 1ns/100ps
module processor_status_register_bank
  import ps_bank_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // status access port
  input  wire logic        ps_rd_en,
  input  wire logic        ps_wr_en,
  input  wire logic [7:0]  ps_num,
  input  wire logic [31:0] ps_wdata,
  input  wire logic        in_debug_mode,
  output logic      [31:0] ps_rdata,
  output logic             ps_rd_valid,
  // tile inputs
  input  wire logic [7:0]  tile_number,
  input  wire logic [7:0]  boot_select_pins,
  input  wire logic        otp_boot_en,
  input  wire logic [31:0] security_word,
  input  wire logic [15:0] event_vector,
  input  wire logic        cores_all_paused,
  // ring oscillator outputs, asynchronous
  input  wire logic [3:0]  osc_wave,
  // debug entry
  input  wire logic        dbg_enter,
  input  wire logic [31:0] saved_status_word,
  input  wire logic [31:0] saved_program_counter,
  input  wire logic [31:0] saved_stack_pointer,
  input  wire logic [2:0]  dbg_cause,
  input  wire logic [3:0]  dbg_unit_hits,
  input  wire logic        dbg_core_valid,
  input  wire logic [7:0]  dbg_core_num,
  input  wire logic [31:0] dbg_data,
  // tile outputs
  output logic      [31:0] ram_base_addr,
  output logic      [31:0] vector_target,
  output logic             clk_div_active,
  output logic      [3:0]  osc_run,
  output logic      [7:0]  dgr_core_sel,
  output logic      [4:0]  dgr_reg_sel,
  output logic      [7:0]  core_stop
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef logic [UNIT_CNT-1:0][31:0] unit_bank_t;

  typedef struct packed {
    logic [31:0]                    ram_base;
    logic [31:0]                    vec_base;
    logic                           div_en;
    logic                           div_dyn;
    logic                           osc_tile;
    logic                           osc_periph;
    logic [3:0][15:0]               cnt;
    logic [3:0]                     sync1;
    logic [3:0]                     sync2;
    logic [3:0]                     sync3;
    logic [31:0]                    dbg_status;
    logic [31:0]                    dbg_pc;
    logic [31:0]                    dbg_sp;
    logic [31:0]                    dgr_core;
    logic [31:0]                    dgr_reg;
    logic [31:0]                    cause;
    logic [31:0]                    dbg_dat;
    logic [31:0]                    stop;
    logic [SCRATCH_CNT-1:0][31:0]   scratch;
    unit_bank_t                     ibp_addr;
    unit_bank_t                     ibp_ctl;
    unit_bank_t                     dwp_lo;
    unit_bank_t                     dwp_hi;
    unit_bank_t                     dwp_ctl;
    unit_bank_t                     rwp_mask;
    unit_bank_t                     rwp_val;
    unit_bank_t                     rwp_ctl;
    logic [31:0]                    rdata;
    logic                           rd_valid;
    logic [31:0]                    vec_target;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic bank4_hit(input logic [7:0] num, input logic [7:0] base);
    bank4_hit = (num[7:2] == base[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [1:0] lowest_unit(input logic [3:0] hits);
    lowest_unit = 2'd0;
    for (int i = UNIT_CNT - 1; i >= 0; i--) begin
      if (hits[i]) begin
        lowest_unit = 2'(i);
      end
    end
  endfunction

  function automatic logic wave_rose(input logic now_v, input logic was_v);
    wave_rose = now_v & ~was_v;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic        wr_any;
  logic        wr_dbg;
  logic [1:0]  uidx;
  logic [2:0]  sidx;
  logic [31:0] rd_word;
  logic        is_unit_cause;

  always_comb begin
    nxt_state = state_ff;
    wr_any = ps_wr_en;
    wr_dbg = ps_wr_en & in_debug_mode;
    uidx   = ps_num[1:0];
    sidx   = ps_num[2:0];

    // ram base, vector base, tile and oscillator control
    if (wr_any && ps_num == NUM_RAM_BASE) begin
      nxt_state.ram_base = merge(state_ff.ram_base, ps_wdata, RAM_BASE_MASK);
    end
    if (wr_any && ps_num == NUM_VEC_BASE) begin
      nxt_state.vec_base = merge(state_ff.vec_base, ps_wdata, VEC_BASE_MASK);
    end
    if (wr_any && ps_num == NUM_TILE_CTL) begin
      nxt_state.div_en  = ps_wdata[TILE_DIV_EN_BIT];
      nxt_state.div_dyn = ps_wdata[TILE_DIV_DYN_BIT];
    end
    if (wr_any && ps_num == NUM_OSC_CTL) begin
      nxt_state.osc_tile   = ps_wdata[OSC_TILE_BIT];
      nxt_state.osc_periph = ps_wdata[OSC_PERIPH_BIT];
    end

    // event target formed from base and vector
    nxt_state.vec_target = {state_ff.vec_base[31:16], event_vector};

    // oscillator waves brought into the tile clock
    // only the second and third stages feed the edge detector; the first may be metastable
    nxt_state.sync1 = osc_wave;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.sync3 = state_ff.sync2;
    // each rising wave edge steps its counter
    for (int i = 0; i < 4; i++) begin
      if (wave_rose(state_ff.sync2[i], state_ff.sync3[i])) begin
        nxt_state.cnt[i] = state_ff.cnt[i] + 16'h0001;
      end
    end

    // ----------------------------------------
    // counter restart
    // ----------------------------------------
    // counts wake up unknown; starting an oscillator group restarts its
    // counters so the count read after stopping is always defined
    if (wr_any && ps_num == NUM_OSC_CTL) begin
      if (ps_wdata[OSC_TILE_BIT] && !state_ff.osc_tile) begin
        nxt_state.cnt[0] = '0;
        nxt_state.cnt[1] = '0;
      end
      if (ps_wdata[OSC_PERIPH_BIT] && !state_ff.osc_periph) begin
        nxt_state.cnt[2] = '0;
        nxt_state.cnt[3] = '0;
      end
    end

    // debug registers written by software in debug mode
    // outside debug mode these writes are dropped without notice
    if (wr_dbg) begin
      case (ps_num)
        NUM_DBG_PC:    nxt_state.dbg_pc = ps_wdata;
        NUM_DBG_SP:    nxt_state.dbg_sp = ps_wdata;
        NUM_DGR_CORE:  nxt_state.dgr_core = ps_wdata & DGR_CORE_MASK;
        NUM_DGR_REG:   nxt_state.dgr_reg  = ps_wdata & DGR_REG_MASK;
        NUM_DBG_CAUSE: nxt_state.cause    = ps_wdata & CAUSE_MASK;
        NUM_DBG_DATA:  nxt_state.dbg_dat  = ps_wdata;
        NUM_CORE_STOP: nxt_state.stop     = ps_wdata & CORE_STOP_MASK;
        default: begin
        end
      endcase
      if (ps_num[7:3] == NUM_SCRATCH[7:3]) begin
        nxt_state.scratch[sidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_IBP_ADDR)) begin
        nxt_state.ibp_addr[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_IBP_CTL)) begin
        nxt_state.ibp_ctl[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_DWP_LO)) begin
        nxt_state.dwp_lo[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_DWP_HI)) begin
        nxt_state.dwp_hi[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_DWP_CTL)) begin
        nxt_state.dwp_ctl[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_RWP_MASK)) begin
        nxt_state.rwp_mask[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_RWP_VAL)) begin
        nxt_state.rwp_val[uidx] = ps_wdata;
      end
      if (bank4_hit(ps_num, NUM_RWP_CTL)) begin
        nxt_state.rwp_ctl[uidx] = ps_wdata;
      end
    end

    // debug entry capture wins over a write in the same cycle
    is_unit_cause = (dbg_cause == CAUSE_INSTR_BP) || (dbg_cause == CAUSE_DATA_WP)
                    || (dbg_cause == CAUSE_RES_WP);
    if (dbg_enter) begin
      nxt_state.dbg_status = saved_status_word;
      nxt_state.dbg_pc     = saved_program_counter;
      nxt_state.dbg_sp     = saved_stack_pointer;
      nxt_state.dbg_dat    = dbg_data;
      nxt_state.cause      = ZERO_WORD;
      nxt_state.cause[2:0] = dbg_cause;
      if (dbg_core_valid) begin
        nxt_state.cause[CAUSE_CORE_LSB +: 8] = dbg_core_num;
      end
      if (is_unit_cause) begin
        nxt_state.cause[CAUSE_UNIT_LSB +: 2] = lowest_unit(dbg_unit_hits);
      end
    end

    // reads see registered state, so a same-cycle write shows next cycle
    // status read returns the addressed word
    rd_word = ZERO_WORD;
    case (ps_num)
      NUM_RAM_BASE:   rd_word = state_ff.ram_base;
      NUM_VEC_BASE:   rd_word = state_ff.vec_base;
      NUM_TILE_CTL: begin
        rd_word[TILE_DIV_EN_BIT]  = state_ff.div_en;
        rd_word[TILE_DIV_DYN_BIT] = state_ff.div_dyn;
      end
      NUM_BOOT_STAT: begin
        rd_word[BOOT_TILE_LSB +: 8] = tile_number;
        rd_word[7:0]                = boot_select_pins;
        rd_word[BOOT_OTP_BIT]       = otp_boot_en;
      end
      NUM_SEC_COPY:   rd_word = security_word;
      NUM_OSC_CTL: begin
        rd_word[OSC_TILE_BIT]   = state_ff.osc_tile;
        rd_word[OSC_PERIPH_BIT] = state_ff.osc_periph;
      end
      NUM_CNT_T_CELL: rd_word[15:0] = state_ff.cnt[0];
      NUM_CNT_T_WIRE: rd_word[15:0] = state_ff.cnt[1];
      NUM_CNT_P_CELL: rd_word[15:0] = state_ff.cnt[2];
      NUM_CNT_P_WIRE: rd_word[15:0] = state_ff.cnt[3];
      NUM_DBG_STATUS: rd_word = state_ff.dbg_status;
      NUM_DBG_PC:     rd_word = state_ff.dbg_pc;
      NUM_DBG_SP:     rd_word = state_ff.dbg_sp;
      NUM_DGR_CORE:   rd_word = state_ff.dgr_core;
      NUM_DGR_REG:    rd_word = state_ff.dgr_reg;
      NUM_DBG_CAUSE:  rd_word = state_ff.cause;
      NUM_DBG_DATA:   rd_word = state_ff.dbg_dat;
      NUM_CORE_STOP:  rd_word = state_ff.stop;
      default: begin
        if (ps_num[7:3] == NUM_SCRATCH[7:3]) begin
          rd_word = state_ff.scratch[sidx];
        end else if (bank4_hit(ps_num, NUM_IBP_ADDR)) begin
          rd_word = state_ff.ibp_addr[uidx];
        end else if (bank4_hit(ps_num, NUM_IBP_CTL)) begin
          rd_word = state_ff.ibp_ctl[uidx];
        end else if (bank4_hit(ps_num, NUM_DWP_LO)) begin
          rd_word = state_ff.dwp_lo[uidx];
        end else if (bank4_hit(ps_num, NUM_DWP_HI)) begin
          rd_word = state_ff.dwp_hi[uidx];
        end else if (bank4_hit(ps_num, NUM_DWP_CTL)) begin
          rd_word = state_ff.dwp_ctl[uidx];
        end else if (bank4_hit(ps_num, NUM_RWP_MASK)) begin
          rd_word = state_ff.rwp_mask[uidx];
        end else if (bank4_hit(ps_num, NUM_RWP_VAL)) begin
          rd_word = state_ff.rwp_val[uidx];
        end else if (bank4_hit(ps_num, NUM_RWP_CTL)) begin
          rd_word = state_ff.rwp_ctl[uidx];
        end else begin
          rd_word = ZERO_WORD;
        end
      end
    endcase
    nxt_state.rd_valid = ps_rd_en;
    if (ps_rd_en) begin
      nxt_state.rdata = rd_word;
    end

    // synchronous reset; counters deliberately left alone
    if (!rst_b) begin
      nxt_state            = '0;
      nxt_state.ram_base   = RAM_BASE_RST;
      nxt_state.cnt        = state_ff.cnt;
      nxt_state.sync1      = osc_wave;
      nxt_state.sync2      = state_ff.sync1;
      nxt_state.sync3      = state_ff.sync2;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ps_rdata      = state_ff.rdata;
  assign ps_rd_valid   = state_ff.rd_valid;
  assign ram_base_addr = state_ff.ram_base;
  assign vector_target = state_ff.vec_target;
  // static always divides, dynamic only when all paused
  assign clk_div_active = state_ff.div_en & (~state_ff.div_dyn | cores_all_paused);
  assign osc_run       = {state_ff.osc_periph, state_ff.osc_periph,
                          state_ff.osc_tile, state_ff.osc_tile};
  assign dgr_core_sel  = state_ff.dgr_core[7:0];
  assign dgr_reg_sel   = state_ff.dgr_reg[4:0];
  assign core_stop     = state_ff.stop[7:0];

endmodule

// ==== testbench/ps_bank_props.sv ====
`timescale 1ns/100ps
// --------------------------------
// status bank checker
// --------------------------------
module ps_bank_props
  import ps_bank_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // status port
  input wire logic        ps_rd_en,
  input wire logic        ps_wr_en,
  input wire logic [7:0]  ps_num,
  input wire logic [31:0] ps_wdata,
  input wire logic        in_debug_mode,
  input wire logic        ps_rd_valid,
  // tile side
  input wire logic [15:0] event_vector,
  input wire logic        cores_all_paused,
  input wire logic [31:0] ram_base_addr,
  input wire logic [31:0] vector_target,
  input wire logic        clk_div_active,
  input wire logic [3:0]  osc_run,
  input wire logic [7:0]  dgr_core_sel,
  input wire logic [4:0]  dgr_reg_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr(logic [7:0] n);
    ps_wr_en && ps_num == n;
  endsequence
  sequence s_wr_dbg(logic [7:0] n);
    s_wr(n) ##0 in_debug_mode;
  endsequence

  property p_rd_answer;
    ps_rd_en |=> ps_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet;
    !ps_rd_en |=> !ps_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without request");
  property p_ram_reset;
    disable iff (1'b0) !rst_b |=> ram_base_addr == RAM_BASE_RST;
  endproperty
  a_ram_reset: assert property (p_ram_reset) else $error("ram base reset value");
  property p_ram_write;
    s_wr(NUM_RAM_BASE) |=> ram_base_addr == ($past(ps_wdata) & RAM_BASE_MASK);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram base write");
  property p_vec_low;
    rst_b ##1 1'b1 |-> vector_target[15:0] == $past(event_vector);
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("event vector half");
  property p_vec_high;
    s_wr(NUM_VEC_BASE) ##1 1'b1 |=> vector_target[31:16] == $past(ps_wdata[31:16], 2);
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("vector base half");
  property p_div_static;
    s_wr(NUM_TILE_CTL) ##0 ps_wdata[5:4] == 2'b01 |=> clk_div_active;
  endproperty
  a_div_static: assert property (p_div_static) else $error("static divider");
  property p_div_off;
    s_wr(NUM_TILE_CTL) ##0 !ps_wdata[4] |=> !clk_div_active;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider not off");
  property p_div_dyn;
    s_wr(NUM_TILE_CTL) ##0 ps_wdata[5:4] == 2'b11 |=> clk_div_active == cores_all_paused;
  endproperty
  a_div_dyn: assert property (p_div_dyn) else $error("dynamic divider");
  property p_osc_run;
    s_wr(NUM_OSC_CTL) |=> osc_run == {{2{$past(ps_wdata[0])}}, {2{$past(ps_wdata[1])}}};
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("oscillator enables");
  property p_osc_reset;
    disable iff (1'b0) !rst_b |=> osc_run == 4'h0 && !clk_div_active;
  endproperty
  a_osc_reset: assert property (p_osc_reset) else $error("control reset value");
  property p_sel_write;
    s_wr_dbg(NUM_DGR_CORE) |=> dgr_core_sel == $past(ps_wdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("core select write");
  property p_reg_write;
    s_wr_dbg(NUM_DGR_REG) |=> dgr_reg_sel == $past(ps_wdata[4:0]);
  endproperty
  a_reg_write: assert property (p_reg_write) else $error("register select write");
  property p_sel_keep;
    s_wr(NUM_DGR_CORE) ##0 !in_debug_mode |=> $stable(dgr_core_sel);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("core select changed");
endmodule

bind processor_status_register_bank ps_bank_props u_ps_bank_props (.*);

// ==== testbench/tb_processor_status_register_bank.sv ====
`timescale 1ns/100ps
module tb_processor_status_register_bank
  import ps_bank_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ps_rd_en = 1'b0;
  logic        ps_wr_en = 1'b0;
  logic        in_debug_mode = 1'b0;
  logic        otp_boot_en = 1'b1;
  logic        cores_all_paused = 1'b0;
  logic        dbg_enter = 1'b0;
  logic        dbg_core_valid = 1'b0;
  logic [7:0]  ps_num = 8'h00;
  logic [7:0]  tile_number = 8'ha5;
  logic [7:0]  boot_select_pins = 8'h3c;
  logic [7:0]  dbg_core_num = 8'h00;
  logic [2:0]  dbg_cause = 3'h0;
  logic [3:0]  osc_wave = 4'h0;
  logic [3:0]  dbg_unit_hits = 4'h0;
  logic [15:0] event_vector = 16'h0000;
  logic [31:0] ps_wdata = 32'h0000_0000;
  logic [31:0] security_word = 32'hc3a5_5a3c;
  logic [31:0] saved_status_word = 32'h0000_0000;
  logic [31:0] saved_program_counter = 32'h0000_0000;
  logic [31:0] saved_stack_pointer = 32'h0000_0000;
  logic [31:0] dbg_data = 32'h0000_0000;
  logic [31:0] ps_rdata;
  logic [31:0] ram_base_addr;
  logic [31:0] vector_target;
  logic        ps_rd_valid;
  logic        clk_div_active;
  logic [3:0]  osc_run;
  logic [7:0]  dgr_core_sel;
  logic [7:0]  core_stop;
  logic [4:0]  dgr_reg_sel;
  int          mismatches = 0;
  int          n_compared = 0;

  processor_status_register_bank dut (.*);

  initial forever #5 clk = ~clk;

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    @(posedge clk);
    ps_wr_en <= 1'b1;
    ps_num   <= n;
    ps_wdata <= d;
    @(posedge clk);
    ps_wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] n, output logic [31:0] d);
    @(posedge clk);
    ps_rd_en <= 1'b1;
    ps_num   <= n;
    @(posedge clk);
    ps_rd_en <= 1'b0;
    #1;
    d = ps_rdata;
  endtask
  task automatic rd_check(input logic [7:0] n, input logic [31:0] exp);
    logic [31:0] d;
    rd(n, d);
    check(d, exp);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset_values;
    rd_check(NUM_RAM_BASE, 32'h0001_0000);
    rd_check(NUM_TILE_CTL, 32'h0000_0000);
    rd_check(NUM_OSC_CTL, 32'h0000_0000);
    rd_check(NUM_DBG_CAUSE, 32'h0000_0000);
    rd_check(8'h04, 32'h0000_0000);
  endtask
  task automatic t_bases;
    wr(NUM_RAM_BASE, 32'hffff_ffff);
    rd_check(NUM_RAM_BASE, 32'hffff_fffc);
    check(ram_base_addr, 32'hffff_fffc);
    wr(NUM_VEC_BASE, 32'hffff_ffff);
    @(posedge clk);
    event_vector <= 16'h1234;
    repeat (2) @(posedge clk);
    #1;
    check(vector_target, 32'hffff_1234);
    rd_check(NUM_VEC_BASE, 32'hffff_0000);
  endtask
  task automatic t_tile_ctl;
    wr(NUM_TILE_CTL, 32'h0000_0010);
    check({31'h0000_0000, clk_div_active}, 32'h0000_0001);
    wr(NUM_TILE_CTL, 32'h0000_0030);
    check({31'h0000_0000, clk_div_active}, 32'h0000_0000);
    @(posedge clk);
    cores_all_paused <= 1'b1;
    #1;
    check({31'h0000_0000, clk_div_active}, 32'h0000_0001);
    wr(NUM_TILE_CTL, 32'hffff_ffff);
    rd_check(NUM_TILE_CTL, 32'h0000_0030);
    wr(NUM_TILE_CTL, 32'h0000_0000);
    check({31'h0000_0000, clk_div_active}, 32'h0000_0000);
  endtask
  task automatic t_boot;
    rd_check(NUM_BOOT_STAT, 32'h00a5_013c);
    @(posedge clk);
    otp_boot_en <= 1'b0;
    rd_check(NUM_BOOT_STAT, 32'h00a5_003c);
    wr(NUM_SEC_COPY, 32'h0000_0000);
    rd_check(NUM_SEC_COPY, 32'hc3a5_5a3c);
  endtask
  task automatic t_osc;
    wr(NUM_OSC_CTL, 32'h0000_0003);
    check({28'h000_0000, osc_run}, 32'h0000_000f);
    repeat (8) begin
      repeat (4) @(posedge clk);
      osc_wave <= ~osc_wave;
    end
    wr(NUM_OSC_CTL, 32'h0000_0000);
    check({28'h000_0000, osc_run}, 32'h0000_0000);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd_check(NUM_CNT_T_CELL + 8'(i), 32'h0000_0004);
    end
    do_reset;
    for (int i = 0; i < 4; i++) begin
      rd_check(NUM_CNT_T_CELL + 8'(i), 32'h0000_0004);
    end
    rd_check(NUM_RAM_BASE, 32'h0001_0000);
  endtask
  task automatic t_debug;
    for (int c = 1; c <= 5; c++) begin
      @(posedge clk);
      dbg_enter             <= 1'b1;
      dbg_cause             <= 3'(c);
      dbg_unit_hits         <= 4'b1010;
      dbg_core_valid        <= c[0];
      dbg_core_num          <= 8'h5a;
      saved_status_word     <= 32'h1000_0000 + 32'(c);
      saved_program_counter <= 32'h2000_0000 + 32'(c);
      saved_stack_pointer   <= 32'h3000_0000 + 32'(c);
      dbg_data              <= 32'h4000_0000 + 32'(c);
      @(posedge clk);
      dbg_enter <= 1'b0;
      rd_check(NUM_DBG_CAUSE, {14'h0000, (c >= 3) ? 2'h1 : 2'h0,
                               c[0] ? 8'h5a : 8'h00, 5'h00, 3'(c)});
      rd_check(NUM_DBG_STATUS, 32'h1000_0000 + 32'(c));
      rd_check(NUM_DBG_PC, 32'h2000_0000 + 32'(c));
      rd_check(NUM_DBG_SP, 32'h3000_0000 + 32'(c));
      rd_check(NUM_DBG_DATA, 32'h4000_0000 + 32'(c));
    end
    @(posedge clk);
    in_debug_mode <= 1'b1;
    wr(NUM_DBG_PC, 32'h1357_9bdf);
    rd_check(NUM_DBG_PC, 32'h1357_9bdf);
    wr(NUM_DBG_STATUS, 32'h0000_0000);
    rd_check(NUM_DBG_STATUS, 32'h1000_0005);
    wr(NUM_DGR_CORE, 32'hffff_ffff);
    rd_check(NUM_DGR_CORE, 32'h0000_00ff);
    wr(NUM_DGR_REG, 32'hffff_ffff);
    rd_check(NUM_DGR_REG, 32'h0000_001f);
    check({27'h000_0000, dgr_reg_sel}, 32'h0000_001f);
    wr(NUM_CORE_STOP, 32'hffff_ffff);
    rd_check(NUM_CORE_STOP, 32'h0000_00ff);
    check({24'h00_0000, core_stop}, 32'h0000_00ff);
    @(posedge clk);
    in_debug_mode <= 1'b0;
    wr(NUM_DGR_CORE, 32'h0000_0000);
    rd_check(NUM_DGR_CORE, 32'h0000_00ff);
  endtask

  initial begin
    do_reset;
    t_reset_values;
    t_bases;
    t_tile_ctl;
    t_boot;
    t_osc;
    t_debug;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
endmodule
